// ===== hw/ascii_can_frame_codec.sv
`timescale 1ns/1ps
// Function
// [R1] Server listens on fixed port after reset
// [R2] One connection; further requests refused
// [R3] Connection loss triggers reboot, resume
// [R4] Only letters and digits, case ignored
// [R5] Valid first char; space before terminator
// [R6] Next message may follow terminator directly
// [R7] Any CR/LF combination ends message
// [R8] Invalid character drops whole message
// [R9] Numbers are bare hex digits
// [R10] Fields separated by space byte
// [R11] Space runs count as one delimiter
// [R12] Bytes in reading order, type first
// [R13] Five kinds told by type field
// [R14] Bus frames encoded and sent to host
// [R15] Valid frame text sent on bus at once
// [R16] Type, descriptor, identifier, zero-eight data
// [R17] Descriptor: format, type, length digit
// [R18] One byte per character
// [R19] Controller command: C, command, parameters
// [R20] Reject length mismatch or identifier overrange
module ascii_can_frame_codec
  import acfc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Connection control from the network stack
  input  wire logic        conn_req,
  input  wire logic        conn_lost,
  output wire logic        srv_listen,
  output wire logic [15:0] listen_port,
  output wire logic        conn_accept,
  output wire logic        conn_reject,
  output wire logic        conn_active,
  output wire logic        reboot_req,
  // Text bytes from host
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  // Text bytes to host
  output wire logic        tx_valid,
  output wire logic [7:0]  tx_data,
  input  wire logic        tx_ready,
  // Frames to bus
  output wire logic        can_tx_valid,
  output wire logic        can_tx_ext,
  output wire logic        can_tx_rtr,
  output wire logic [3:0]  can_tx_dlc,
  output wire logic [28:0] can_tx_id,
  output wire logic [63:0] can_tx_data,
  // Frames from bus
  input  wire logic        can_rx_valid,
  input  wire logic        can_rx_ext,
  input  wire logic        can_rx_rtr,
  input  wire logic [3:0]  can_rx_dlc,
  input  wire logic [28:0] can_rx_id,
  input  wire logic [63:0] can_rx_data,
  output wire logic        can_rx_ready,
  // Non-frame messages
  output wire logic        msg_valid,
  output wire logic [2:0]  msg_kind
);

  typedef struct packed {
    logic          listen;   // Server up
    logic [15:0]   port;     // Listening port
    logic          active;   // Connection open
    logic          accept;   // Accept pulse
    logic          reject;   // Reject pulse
    logic          reboot;   // Reboot pulse
    logic          started;  // Message begun
    logic          in_field; // Inside a field
    logic          prev_sp;  // Last byte a space
    logic          bad;      // Message to drop
    logic [3:0]    field_cnt;// Fields begun
    logic [3:0]    fchars;   // Chars in field
    acfc_kind_type kind;     // Message kind
    logic          desc_ok;  // Descriptor complete
    logic          ext;      // Extended format
    logic          rtr;      // Remote frame
    logic [3:0]    dlc;      // Length code
    logic [31:0]   id;       // Identifier
    logic [63:0]   data;     // Payload, byte 0 low
    logic          ctx_v;    // Bus frame pulse
    logic          ctx_ext;  // Bus frame format
    logic          ctx_rtr;  // Bus frame type
    logic [3:0]    ctx_dlc;  // Bus frame length
    logic [28:0]   ctx_id;   // Bus frame id
    logic [63:0]   ctx_data; // Bus frame data
    logic          mv;       // Message pulse
    logic [2:0]    mk;       // Message kind
  } acfc_top_state_type;

  acfc_top_state_type s;        // Registered state
  acfc_top_state_type n;        // Next state
  acfc_tx_if          txc ();   // Encoder stream
  logic [7:0]         lc;       // Lower-cased byte
  logic               is_upper; // A..Z
  logic               is_lower; // a..z
  logic               is_dig;   // 0..9
  logic               is_hex;   // Hex digit
  logic               is_term;  // CR or LF
  logic               is_sp;    // Space
  logic [3:0]         nib;      // Hex value
  logic [3:0]         ndata;    // Expected data fields
  logic               msg_ok;   // Syntax clean
  logic               cnt_ok;   // Data count fits
  logic               id_ok;    // Identifier in range
  logic               frame_ok; // Frame to send
  logic               cmd_ok;   // Other kind to pass
  logic               take;     // Byte consumed
  logic [3:0]         f;        // Current field index
  logic [3:0]         p;        // Position in field
  logic [3:0]         k;        // Data byte index

  // Output ports from state
  assign srv_listen   = s.listen;
  assign listen_port  = s.port;
  assign conn_accept  = s.accept;
  assign conn_reject  = s.reject;
  assign conn_active  = s.active;
  assign reboot_req   = s.reboot;
  assign can_tx_valid = s.ctx_v;
  assign can_tx_ext   = s.ctx_ext;
  assign can_tx_rtr   = s.ctx_rtr;
  assign can_tx_dlc   = s.ctx_dlc;
  assign can_tx_id    = s.ctx_id;
  assign can_tx_data  = s.ctx_data;
  assign msg_valid    = s.mv;
  assign msg_kind     = s.mk;
  assign tx_valid     = txc.valid;
  assign tx_data      = txc.data;
  assign txc.ready    = tx_ready;

  // Byte classes, case folded
  always_comb begin
    is_upper = (rx_data >= ACFC_CH_UA) && (rx_data <= ACFC_CH_UZ);
    is_lower = (rx_data >= ACFC_CH_LA) && (rx_data <= ACFC_CH_LZ);
    is_dig   = (rx_data >= ACFC_CH_0) && (rx_data <= ACFC_CH_9);
    lc       = is_upper ? (rx_data | ACFC_CASE_BIT) : rx_data; // [R4]
    is_hex   = is_dig || ((lc >= ACFC_CH_LA) && (lc <= ACFC_CH_LF_HEX)); // [R9]
    nib      = is_dig ? rx_data[3:0] : lc[3:0] + 4'h9;
    is_term  = (rx_data == ACFC_CH_CR) || (rx_data == ACFC_CH_LF);
    is_sp    = (rx_data == ACFC_CH_SP);
    take     = rx_valid && s.active && !conn_lost;
  end

  // Checks applied at the terminator
  always_comb begin
    ndata    = s.rtr ? 4'h0 : s.dlc;
    msg_ok   = s.started && !s.bad && s.prev_sp; // [R5]
    cnt_ok   = (s.field_cnt >= ACFC_DATA_FIELD) && (s.field_cnt - ACFC_DATA_FIELD == ndata); // [R20] [R16]
    id_ok    = s.ext ? (s.id <= ACFC_EXT_ID_MAX) : (s.id <= ACFC_STD_ID_MAX); // [R20]
    frame_ok = msg_ok && (s.kind == ACFC_KIND_FRAME) && s.desc_ok && cnt_ok && id_ok;
    cmd_ok   = msg_ok && ((((s.kind == ACFC_KIND_CTRL) || (s.kind == ACFC_KIND_DEV))
               && (s.field_cnt >= ACFC_CMD_FIELDS)) || (s.kind == ACFC_KIND_ERR)
               || (s.kind == ACFC_KIND_INFO)); // [R19]
  end

  // Connection handling and message parser
  always_comb begin
    n = s;
    f = 4'h0;
    p = 4'h0;
    k = 4'h0;
    if (clk_en) begin
      n.accept = 1'b0;
      n.reject = 1'b0;
      n.reboot = 1'b0;
      n.ctx_v  = 1'b0;
      n.mv     = 1'b0;
      n.listen = 1'b1; // [R1]
      n.port   = ACFC_TCP_PORT;
      if (conn_lost && s.active) begin // [R3]
        n = '0;
        n.reboot = 1'b1;
      end else if (conn_req) begin
        if (s.active || !s.listen) begin // [R2]
          n.reject = 1'b1;
        end else begin
          n.accept = 1'b1;
          n.active = 1'b1;
        end
      end
      if (take) begin
        if (is_term) begin // [R7]
          if (s.started) begin
            if (frame_ok) begin // [R15]
              n.ctx_v    = 1'b1;
              n.ctx_ext  = s.ext;
              n.ctx_rtr  = s.rtr;
              n.ctx_dlc  = s.dlc;
              n.ctx_id   = s.id[28:0];
              n.ctx_data = s.data;
            end else if (cmd_ok) begin // [R13]
              n.mv = 1'b1;
              n.mk = s.kind;
            end
            // Ready for next message at once [R6]
            n.started   = 1'b0;
            n.in_field  = 1'b0;
            n.prev_sp   = 1'b0;
            n.bad       = 1'b0;
            n.field_cnt = 4'h0;
            n.fchars    = 4'h0;
            n.kind      = ACFC_KIND_NONE;
            n.desc_ok   = 1'b0;
            n.ext       = 1'b0;
            n.rtr       = 1'b0;
            n.dlc       = 4'h0;
            n.id        = 32'h0000_0000;
            n.data      = 64'h0000_0000_0000_0000;
          end
        end else if (is_sp) begin // [R10] [R11]
          n.in_field = 1'b0;
          n.prev_sp  = 1'b1;
          if (!s.started) begin // [R5]
            n.started = 1'b1;
            n.bad     = 1'b1;
          end
        end else if (is_upper || is_lower || is_dig) begin // [R18]
          n.started = 1'b1;
          n.prev_sp = 1'b0;
          if (!s.in_field) begin
            n.in_field  = 1'b1;
            n.fchars    = 4'h0;
            n.field_cnt = (s.field_cnt == ACFC_FIELD_SAT) ? s.field_cnt : s.field_cnt + 4'h1;
          end
          f        = n.field_cnt - 4'h1;
          p        = n.fchars;
          n.fchars = (p == ACFC_FIELD_SAT) ? p : p + 4'h1;
          if (f == 4'h0) begin // [R12] [R13]
            if (p != 4'h0) begin
              n.kind = ACFC_KIND_NONE;
            end else begin
              unique case (lc)
                ACFC_LC_M: n.kind = ACFC_KIND_FRAME;
                ACFC_LC_C: n.kind = ACFC_KIND_CTRL;
                ACFC_LC_D: n.kind = ACFC_KIND_DEV;
                ACFC_LC_E: n.kind = ACFC_KIND_ERR;
                ACFC_LC_I: n.kind = ACFC_KIND_INFO;
                default:   n.kind = ACFC_KIND_NONE;
              endcase
            end
          end else if (s.kind == ACFC_KIND_FRAME) begin
            if (f == 4'h1) begin // [R17]
              unique case (p)
                4'h0: begin
                  n.ext = (lc == ACFC_LC_E);
                  if ((lc != ACFC_LC_E) && (lc != ACFC_LC_S)) begin
                    n.bad = 1'b1;
                  end
                end
                4'h1: begin
                  n.rtr = (lc == ACFC_LC_R);
                  if ((lc != ACFC_LC_R) && (lc != ACFC_LC_D)) begin
                    n.bad = 1'b1;
                  end
                end
                ACFC_DESC_LAST: begin
                  n.dlc     = rx_data[3:0];
                  n.desc_ok = is_dig && (rx_data <= ACFC_CH_8);
                  n.bad     = s.bad || !n.desc_ok;
                end
                default: n.bad = 1'b1;
              endcase
            end else if (f == ACFC_ID_FIELD) begin // [R9]
              n.id = {s.id[27:0], nib};
              if (!is_hex || (p >= ACFC_ID_DIGITS)) begin
                n.bad = 1'b1;
              end
            end else begin // [R16]
              k = f - ACFC_DATA_FIELD;
              if (!is_hex || (p >= ACFC_BYTE_DIGS) || (k >= ACFC_MAX_DATA)) begin
                n.bad = 1'b1;
              end else begin
                n.data[{k[2:0], 3'h0} +: 8] = {s.data[{k[2:0], 3'h0} +: 4], nib};
              end
            end
          end
        end else begin // [R8]
          n.started = 1'b1;
          n.prev_sp = 1'b0;
          n.bad     = 1'b1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Frames from bus to host text, only while connected
  acfc_frame_encoder u_enc (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .frm_valid (can_rx_valid && s.active),
    .frm_ext   (can_rx_ext),
    .frm_rtr   (can_rx_rtr),
    .frm_dlc   (can_rx_dlc),
    .frm_id    (can_rx_id),
    .frm_data  (can_rx_data),
    .frm_ready (can_rx_ready),
    .tx        (txc.src)
  );

  property p_listen;
    @(posedge clk) disable iff (sys_rst)
      clk_en && !s.listen |=> s.listen && s.port == ACFC_TCP_PORT;
  endproperty
  a_listen: assert property (p_listen) else $error("server not started"); // [R1]

  property p_single;
    @(posedge clk) disable iff (sys_rst)
      clk_en && conn_req && s.active && !conn_lost |=> conn_reject && !conn_accept && conn_active;
  endproperty
  a_single: assert property (p_single) else $error("second connection not refused"); // [R2]

  property p_reboot;
    @(posedge clk) disable iff (sys_rst)
      clk_en && conn_lost && s.active |=> reboot_req && !conn_active ##1 !reboot_req;
  endproperty
  a_reboot: assert property (p_reboot) else $error("no reboot on loss"); // [R3]

  property p_drop;
    @(posedge clk) disable iff (sys_rst)
      clk_en && take && is_term && s.started && s.bad |=> !can_tx_valid && !msg_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("bad message not dropped"); // [R8]

  property p_send;
    @(posedge clk) disable iff (sys_rst)
      clk_en && take && is_term && frame_ok |=> can_tx_valid && can_tx_id == $past(s.id[28:0]);
  endproperty
  a_send: assert property (p_send) else $error("frame not sent"); // [R15]

  property p_count;
    @(posedge clk) disable iff (sys_rst)
      clk_en && take && is_term && s.kind == ACFC_KIND_FRAME && (!cnt_ok || !id_ok) |=> !can_tx_valid;
  endproperty
  a_count: assert property (p_count) else $error("mismatched frame sent"); // [R20]

  property p_next;
    @(posedge clk) disable iff (sys_rst)
      clk_en && take && is_term |=> !s.started && s.field_cnt == 4'h0;
  endproperty
  a_next: assert property (p_next) else $error("parser not ready after terminator"); // [R6]

  property p_spaces;
    @(posedge clk) disable iff (sys_rst)
      clk_en && take && is_sp && s.prev_sp |=> $stable(s.field_cnt) && s.prev_sp;
  endproperty
  a_spaces: assert property (p_spaces) else $error("space run split a field"); // [R11]

endmodule // ascii_can_frame_codec

// ===== hw/acfc_pkg.sv
package acfc_pkg;

  // Protocol server listening port, 19227
  localparam logic [15:0] ACFC_TCP_PORT   = 16'h4B1B;

  // Byte codes of the text stream
  localparam logic [7:0]  ACFC_CH_SP      = 8'h20;
  localparam logic [7:0]  ACFC_CH_CR      = 8'h0D;
  localparam logic [7:0]  ACFC_CH_LF      = 8'h0A;
  localparam logic [7:0]  ACFC_CH_0       = 8'h30;
  localparam logic [7:0]  ACFC_CH_8       = 8'h38;
  localparam logic [7:0]  ACFC_CH_9       = 8'h39;
  localparam logic [7:0]  ACFC_CH_UA      = 8'h41;
  localparam logic [7:0]  ACFC_CH_UZ      = 8'h5A;
  localparam logic [7:0]  ACFC_CH_LA      = 8'h61;
  localparam logic [7:0]  ACFC_CH_LF_HEX  = 8'h66;
  localparam logic [7:0]  ACFC_CH_LZ      = 8'h7A;
  localparam logic [7:0]  ACFC_CASE_BIT   = 8'h20;
  localparam logic [7:0]  ACFC_HEX_LO     = 8'h30;
  localparam logic [7:0]  ACFC_HEX_HI     = 8'h37;

  // Lower-case letters seen by the parser
  localparam logic [7:0]  ACFC_LC_M       = 8'h6D;
  localparam logic [7:0]  ACFC_LC_C       = 8'h63;
  localparam logic [7:0]  ACFC_LC_D       = 8'h64;
  localparam logic [7:0]  ACFC_LC_E       = 8'h65;
  localparam logic [7:0]  ACFC_LC_I       = 8'h69;
  localparam logic [7:0]  ACFC_LC_S       = 8'h73;
  localparam logic [7:0]  ACFC_LC_R       = 8'h72;

  // Upper-case letters sent by the encoder
  localparam logic [7:0]  ACFC_UC_M       = 8'h4D;
  localparam logic [7:0]  ACFC_UC_S       = 8'h53;
  localparam logic [7:0]  ACFC_UC_E       = 8'h45;
  localparam logic [7:0]  ACFC_UC_D       = 8'h44;
  localparam logic [7:0]  ACFC_UC_R       = 8'h52;

  // Frame field limits
  localparam logic [3:0]  ACFC_MAX_DATA   = 4'h8;
  localparam logic [3:0]  ACFC_ID_FIELD   = 4'h2;
  localparam logic [3:0]  ACFC_DATA_FIELD = 4'h3;
  localparam logic [3:0]  ACFC_DESC_LAST  = 4'h2;
  localparam logic [3:0]  ACFC_ID_DIGITS  = 4'h8;
  localparam logic [3:0]  ACFC_BYTE_DIGS  = 4'h2;
  localparam logic [3:0]  ACFC_CMD_FIELDS = 4'h2;
  localparam logic [3:0]  ACFC_FIELD_SAT  = 4'hF;
  localparam logic [3:0]  ACFC_STD_DIGS   = 4'h3;
  localparam logic [3:0]  ACFC_EXT_DIGS   = 4'h8;
  localparam logic [3:0]  ACFC_HEAD_LAST  = 4'h5;
  localparam logic [31:0] ACFC_STD_ID_MAX = 32'h0000_07FF;
  localparam logic [31:0] ACFC_EXT_ID_MAX = 32'h1FFF_FFFF;

  // Message kinds by leading type field
  typedef enum logic [2:0] {
    ACFC_KIND_NONE  = 3'h0,
    ACFC_KIND_FRAME = 3'h1,
    ACFC_KIND_CTRL  = 3'h2,
    ACFC_KIND_DEV   = 3'h3,
    ACFC_KIND_ERR   = 3'h4,
    ACFC_KIND_INFO  = 3'h5
  } acfc_kind_type;

  // Encoder output phases
  typedef enum logic [2:0] {
    ACFC_ENC_IDLE = 3'h0,
    ACFC_ENC_HEAD = 3'h1,
    ACFC_ENC_ID   = 3'h2,
    ACFC_ENC_SP   = 3'h3,
    ACFC_ENC_DATA = 3'h4,
    ACFC_ENC_CR   = 3'h5,
    ACFC_ENC_LF   = 3'h6
  } acfc_enc_phase_type;

  // Nibble to upper-case hex character
  function automatic logic [7:0] acfc_hex(input logic [3:0] v);
    return (v < 4'hA) ? ACFC_HEX_LO + {4'h0, v} : ACFC_HEX_HI + {4'h0, v};
  endfunction

endpackage

// ===== hw/acfc_tx_if.sv
`timescale 1ns/1ps
// Byte stream from encoder to host side
interface acfc_tx_if;
  logic       valid;  // Byte offered
  logic [7:0] data;   // Text byte
  logic       ready;  // Byte taken
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== hw/acfc_frame_encoder.sv
`timescale 1ns/1ps
module acfc_frame_encoder
  import acfc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Frame from bus
  input  wire logic        frm_valid,
  input  wire logic        frm_ext,
  input  wire logic        frm_rtr,
  input  wire logic [3:0]  frm_dlc,
  input  wire logic [28:0] frm_id,
  input  wire logic [63:0] frm_data,
  output wire logic        frm_ready,
  // Text bytes out
  acfc_tx_if.src           tx
);

  typedef struct packed {
    acfc_enc_phase_type phase;    // Output phase
    logic [3:0]         idx;      // Char or nibble index
    logic [3:0]         byte_idx; // Data byte in progress
    logic               ext;      // Extended format
    logic               rtr;      // Remote frame
    logic [3:0]         dlc;      // Length code
    logic [31:0]        id;       // Identifier, padded
    logic [63:0]        data;     // Payload, byte 0 low
    logic               tx_valid; // Byte offered
    logic [7:0]         tx_data;  // Byte value
    logic               ready;    // Idle, frame accepted
  } acfc_enc_state_type;

  acfc_enc_state_type s;      // Registered state
  acfc_enc_state_type n;      // Next state
  logic [3:0]         nbytes; // Data fields to send
  logic [7:0]         head;   // Header character

  assign nbytes    = s.rtr ? 4'h0 : s.dlc;
  assign frm_ready = s.ready;
  assign tx.valid  = s.tx_valid;
  assign tx.data   = s.tx_data;

  // Header characters: type, descriptor, delimiters
  always_comb begin
    unique case (s.idx)
      4'h0:    head = ACFC_UC_M;
      4'h2:    head = s.ext ? ACFC_UC_E : ACFC_UC_S;
      4'h3:    head = s.rtr ? ACFC_UC_R : ACFC_UC_D;
      4'h4:    head = ACFC_CH_0 + {4'h0, s.dlc};
      default: head = ACFC_CH_SP;
    endcase
  end

  // Emit one text byte per free slot
  always_comb begin
    n = s;
    if (clk_en) begin
      if (s.tx_valid && tx.ready) begin
        n.tx_valid = 1'b0;
      end
      if (s.phase == ACFC_ENC_IDLE) begin
        if (frm_valid) begin // [R14]
          n.phase    = ACFC_ENC_HEAD;
          n.idx      = 4'h0;
          n.byte_idx = 4'h0;
          n.ext      = frm_ext;
          n.rtr      = frm_rtr;
          n.dlc      = frm_dlc;
          n.id       = {3'h0, frm_id};
          n.data     = frm_data;
        end
      end else if (!s.tx_valid || tx.ready) begin // [R12] [R18]
        n.tx_valid = 1'b1;
        unique case (s.phase)
          ACFC_ENC_HEAD: begin // [R17]
            n.tx_data = head;
            if (s.idx == ACFC_HEAD_LAST) begin
              n.phase = ACFC_ENC_ID;
              n.idx   = (s.ext ? ACFC_EXT_DIGS : ACFC_STD_DIGS) - 4'h1;
            end else begin
              n.idx = s.idx + 4'h1;
            end
          end
          ACFC_ENC_ID: begin // [R9]
            n.tx_data = acfc_hex(s.id[{s.idx[2:0], 2'h0} +: 4]);
            if (s.idx == 4'h0) begin
              n.phase = ACFC_ENC_SP;
            end else begin
              n.idx = s.idx - 4'h1;
            end
          end
          ACFC_ENC_SP: begin // [R10] [R5]
            n.tx_data = ACFC_CH_SP;
            if (s.byte_idx < nbytes) begin // [R16]
              n.phase = ACFC_ENC_DATA;
              n.idx   = 4'h1;
            end else begin
              n.phase = ACFC_ENC_CR;
            end
          end
          ACFC_ENC_DATA: begin
            n.tx_data = acfc_hex(s.data[{s.byte_idx[2:0], s.idx[0], 2'h0} +: 4]);
            if (s.idx == 4'h0) begin
              n.phase    = ACFC_ENC_SP;
              n.byte_idx = s.byte_idx + 4'h1;
            end else begin
              n.idx = s.idx - 4'h1;
            end
          end
          ACFC_ENC_CR: begin
            n.tx_data = ACFC_CH_CR;
            n.phase   = ACFC_ENC_LF;
          end
          ACFC_ENC_LF: begin
            n.tx_data = ACFC_CH_LF;
            n.phase   = ACFC_ENC_IDLE;
          end
          default: begin
            n.tx_valid = 1'b0;
            n.phase    = ACFC_ENC_IDLE;
          end
        endcase
      end
      n.ready = (n.phase == ACFC_ENC_IDLE);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Accepted frame starts the header
  property p_enc_start;
    @(posedge clk) disable iff (sys_rst)
      clk_en && frm_valid && s.ready |=> s.phase == ACFC_ENC_HEAD && s.idx == 4'h0 && !s.ready;
  endproperty
  a_enc_start: assert property (p_enc_start) else $error("frame not taken"); // [R14]

  // First byte of a message is the type letter
  property p_enc_type;
    @(posedge clk) disable iff (sys_rst)
      clk_en && s.phase == ACFC_ENC_HEAD && s.idx == 4'h0 && (!s.tx_valid || tx.ready)
        |=> s.tx_valid && s.tx_data == ACFC_UC_M;
  endproperty
  a_enc_type: assert property (p_enc_type) else $error("message not led by type"); // [R12]

endmodule // acfc_frame_encoder

// ===== verif/acfc_host_model.sv
`timescale 1ns/1ps
// Host side: sends text, collects returned text
module acfc_host_model (
  // Clock
  input  wire logic       clk,
  // Text to device
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  // Text from device
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  byte unsigned got[$];  // Bytes seen
  logic         slow;    // Stall every other cycle
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end
  // Take offered bytes
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // One byte per cycle in reading order
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_data  <= s[i];
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data; // No stale byte left
    @(posedge clk);
  endtask
endmodule // acfc_host_model

// ===== verif/tb_ascii_can_frame_codec.sv
`timescale 1ns/1ps
module tb_ascii_can_frame_codec;
  import acfc_pkg::*;
  logic clk = 0, sys_rst = 1, clk_en = 1, conn_req = 0, conn_lost = 0, rx_valid, tx_valid, tx_ready;
  logic srv_listen, conn_accept, conn_reject, conn_active, reboot_req, can_tx_valid, can_tx_ext, can_tx_rtr;
  logic can_rx_valid = 0, can_rx_ext = 0, can_rx_rtr = 0, can_rx_ready, msg_valid;
  logic [15:0] listen_port;
  logic [7:0] rx_data, tx_data;
  logic [3:0] can_tx_dlc, can_rx_dlc = 0;
  logic [28:0] can_tx_id, can_rx_id = 0;
  logic [63:0] can_tx_data, can_rx_data = 0;
  logic [2:0] msg_kind;
  logic [63:0] frm[$];  // Frames seen on bus side
  int n_acc, n_rej, n_rbt, n_msg, mismatches, num_checks;
  always #50 clk = ~clk;
  ascii_can_frame_codec u_ascii_can_frame_codec (.clk, .sys_rst, .clk_en, .conn_req, .conn_lost, .srv_listen,
    .listen_port, .conn_accept, .conn_reject, .conn_active, .reboot_req, .rx_valid, .rx_data, .tx_valid,
    .tx_data, .tx_ready, .can_tx_valid, .can_tx_ext, .can_tx_rtr, .can_tx_dlc, .can_tx_id, .can_tx_data,
    .can_rx_valid, .can_rx_ext, .can_rx_rtr, .can_rx_dlc, .can_rx_id, .can_rx_data, .can_rx_ready,
    .msg_valid, .msg_kind);
  acfc_host_model u_acfc_host_model (.clk, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready);
  // Count output pulses
  always @(posedge clk) begin
    n_acc += conn_accept;
    n_rej += conn_reject;
    n_rbt += reboot_req;
    n_msg += msg_valid;
    if (can_tx_valid) frm.push_back({can_tx_ext, can_tx_rtr, can_tx_dlc, can_tx_id, can_tx_data[15:0]});
  end
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One-cycle request or loss
  task automatic pulse(logic lost);
    conn_req <= !lost;
    conn_lost <= lost;
    @(posedge clk);
    conn_req <= 0;
    conn_lost <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_connect();
    check("listen", srv_listen, 1);
    check("port", listen_port, 16'd19227);
    pulse(0);
    pulse(0);
    check("accepts", n_acc, 1);
    check("rejects", n_rej, 1);
    check("active", conn_active, 1);
    // Request while frozen must leave no trace
    clk_en <= 0;
    pulse(0);
    clk_en <= 1;
    check("frozen", n_rej, 1);
  endtask
  // Back-to-back frames, lower case, space run
  task automatic t_text();
    u_acfc_host_model.send("m  ed2 1fffffff 1 ab \rM SR0 7FF \n\r");
    repeat (2) @(posedge clk);
    check("frames", frm.size(), 2);
    if (frm.size() == 2) begin
      check("ext", frm[0], {2'b10, 4'h2, 29'h1FFFFFFF, 16'hAB01});
      check("rtr", frm[1][50:16], {2'b01, 4'h0, 29'h7FF});
    end
  endtask
  // Bad character, radix prefix, count or range wrong, no space
  task automatic t_drop();
    u_acfc_host_model.send("M SD1 7 # \rM SD1 0x7 A \rM SD2 7 A \rM SD0 800 \rM SD1 7 A\r");
    repeat (2) @(posedge clk);
    check("dropped", frm.size(), 2);
  endtask
  task automatic t_kinds();
    string k[4] = '{"C START \r", "D VER \n", "e x \r", "I OK \r\n"};
    foreach (k[i]) begin
      u_acfc_host_model.send(k[i]);
      repeat (2) @(posedge clk);
      check("kind", msg_kind, 2 + i);
    end
    check("msgs", n_msg, 4);
  endtask
  // Bus frame to host text, host stalling
  task automatic t_bus();
    string e = "M SD1 012 AB \r\n";
    u_acfc_host_model.slow = 1;
    can_rx_valid <= 1;
    can_rx_dlc <= 4'h1;
    can_rx_id <= 29'h12;
    can_rx_data <= 64'hAB;
    @(negedge clk);
    for (int i = 0; i < 20 && !can_rx_ready; i++) @(negedge clk);
    check("rx ready", can_rx_ready, 1);
    if (can_rx_ready !== 1'b1) report_and_stop();
    @(posedge clk);
    can_rx_valid <= 0;
    for (int i = 0; i < 300 && u_acfc_host_model.got.size() < 15; i++) @(posedge clk);
    check("length", u_acfc_host_model.got.size(), 15);
    if (u_acfc_host_model.got.size() != 15) report_and_stop();
    for (int i = 0; i < e.len(); i++) check("text", u_acfc_host_model.got[i], e[i]);
  endtask
  task automatic t_lost();
    pulse(1);
    check("reboot", n_rbt, 1);
    check("inactive", conn_active, 0);
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    repeat (3) @(posedge clk);
    t_connect();
    t_text();
    t_drop();
    t_kinds();
    t_bus();
    t_lost();
    report_and_stop();
  end
endmodule // tb_ascii_can_frame_codec
